// >>> hw/can_mb_consts.svh
// Constants for the message-buffer handling block: map, fields and sizes.
`ifndef CAN_MB_CONSTS_SVH
`define CAN_MB_CONSTS_SVH
`define NBUF        16
`define IDXW        4
`define ABT_LAST    4'h7
`define HDEPTH      8
`define HPTRW       3
`define ADDRW       12
`define OFF_GCTRL   12'h000
`define OFF_TXHIST  12'h004
`define OFF_RXHIST  12'h008
`define OFF_LAST    12'h00C
`define BCTL_SEL    6'h01
`define BDATA_SEL   6'h02
`define G_ABT       0
`define G_TRG       1
`define G_TX_IN_PROGRESS_STATUS     2
`define G_BUFFER_ACCESS_ON      3
`define G_TX_HISTORY_OVERFLOW      4
`define G_RX_HISTORY_OVERFLOW      5
`define B_RDY       0
`define B_TRQ       1
`define B_DN        2
`define B_MUC       3
`define B_TYPE_LO   4
`define B_TYPE_HI   6
`define B_ASSIGN    7
`define H_EMPTY     8
`define L_RX_LO     8
`define L_RX_HI     11
`define TYPE_TX     3'h0
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hw/can_mb_core.sv
// Message-buffer handling of a CAN controller with an AXI4-Lite register port.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "can_mb_consts.svh"
module can_mb_core (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [`ADDRW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic      [1:0]        bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [`ADDRW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic      [31:0]       rdata,
    output logic      [1:0]        rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Protocol layer: transmit
    output logic                   tx_req_valid,
    output logic      [`IDXW-1:0]  tx_req_index,
    input  wire logic              tx_accept,
    input  wire logic              tx_done,
    // Protocol layer: receive
    input  wire logic              rx_valid,
    input  wire logic [`IDXW-1:0]  rx_index,
    input  wire logic [31:0]       rx_data,
    // Power mode events
    input  wire logic              sleep_taken,
    input  wire logic              wake_taken
);
    // ==========================================================
    // Address decode
    function automatic logic is_bctl(input logic [`ADDRW-1:0] a);
        return a[`ADDRW-1:6] == `BCTL_SEL;
    endfunction
    function automatic logic is_bdata(input logic [`ADDRW-1:0] a);
        return a[`ADDRW-1:6] == `BDATA_SEL;
    endfunction
    function automatic logic is_mapped(input logic [`ADDRW-1:0] a);
        return is_bctl(a) || is_bdata(a) || a == `OFF_GCTRL || a == `OFF_TXHIST
               || a == `OFF_RXHIST || a == `OFF_LAST;
    endfunction
    // Lowest set bit wins; the top bit of the result says whether one was found.
    function automatic logic [`IDXW:0] pick(input logic [`NBUF-1:0] m);
        logic [`IDXW:0] r;
        r = '0;
        for (int i = `NBUF - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, `IDXW'(i)};
            end
        end
        return r;
    endfunction

    // ==========================================================
    // State
    logic [`ADDRW-1:0] aw_addr, ar_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_have, w_have, ar_pend;
    logic [`NBUF-1:0]  rdy, transmit_request, dn, buffer_update_in_progress, asg;
    logic [2:0]        btype [`NBUF];
    logic              auto_block_transmission, trg, buffer_access_on, from_abt;
    logic [`IDXW-1:0]  abt_ptr, tx_idx, rx_idx, last_tx, last_rx;
    logic [31:0]       rx_word;
    can_mb_pkg::tx_state_t tx_state, next_tx_state;
    can_mb_pkg::rx_state_t rx_state, next_rx_state;
    logic [`NBUF-1:0]  next_rdy, next_trq, next_dn, next_muc, next_asg;
    logic [2:0]        next_btype [`NBUF];
    logic              next_abt, next_trg, next_buffer_access_on, next_from_abt;
    logic [`IDXW-1:0]  next_abt_ptr, next_tx_idx, next_last_tx, next_last_rx;
    logic [`NBUF-1:0]  elig, normal_set;
    logic [`IDXW:0]    cand;
    logic              do_wr, do_rd, tx_stat;
    logic [31:0]       ram_q, rd_word;
    logic [3:0]        ram_we;
    logic [`IDXW-1:0]  tx_head, rx_head;
    logic              tx_empty, rx_empty, tx_full, rx_full, tx_history_overflow, rx_history_overflow;
    logic              tx_push, rx_push, tx_pop, rx_pop;

    // ==========================================================
    // AXI4-Lite slave
    assign awready = !aw_have;
    assign wready  = !w_have;
    assign arready = !ar_pend && !rvalid;
    assign do_rd   = arvalid && arready;
    // A data write waits while a received frame owns the store's write port.
    assign do_wr   = aw_have && w_have && !bvalid && !(is_bdata(aw_addr) && rx_state == can_mb_pkg::RX_WRITE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            ar_addr <= '0;
            ar_pend <= 1'b0;
            rvalid  <= 1'b0;
            rresp   <= `RESP_OKAY;
            rdata   <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_addr <= awaddr;
                aw_have <= 1'b1;
            end else if (do_wr) begin
                aw_have <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data <= wdata;
                w_strb <= wstrb;
                w_have <= 1'b1;
            end else if (do_wr) begin
                w_have <= 1'b0;
            end
            if (do_wr) begin
                bvalid <= 1'b1;
                bresp  <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (do_rd) begin
                ar_addr <= araddr;
                ar_pend <= 1'b1;
            end else if (ar_pend) begin
                ar_pend <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_word;
                rresp   <= is_mapped(ar_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Read mux; reading a history word also takes its head entry off the list.
    assign tx_pop = ar_pend && ar_addr == `OFF_TXHIST;
    assign rx_pop = ar_pend && ar_addr == `OFF_RXHIST;
    always_comb begin
        rd_word = '0;
        if (ar_addr == `OFF_GCTRL) begin
            rd_word[`G_ABT]   = auto_block_transmission;
            rd_word[`G_TRG]   = trg;
            rd_word[`G_TX_IN_PROGRESS_STATUS] = tx_stat;
            rd_word[`G_BUFFER_ACCESS_ON]  = buffer_access_on;
            rd_word[`G_TX_HISTORY_OVERFLOW]  = tx_history_overflow;
            rd_word[`G_RX_HISTORY_OVERFLOW]  = rx_history_overflow;
        end else if (ar_addr == `OFF_TXHIST) begin
            rd_word[`IDXW-1:0] = tx_head;
            rd_word[`H_EMPTY]  = tx_empty;
        end else if (ar_addr == `OFF_RXHIST) begin
            rd_word[`IDXW-1:0] = rx_head;
            rd_word[`H_EMPTY]  = rx_empty;
        end else if (ar_addr == `OFF_LAST) begin
            rd_word[`IDXW-1:0]         = last_tx;
            rd_word[`L_RX_HI:`L_RX_LO] = last_rx;
        end else if (is_bctl(ar_addr)) begin
            rd_word[`B_RDY]                 = rdy[ar_addr[5:2]];
            rd_word[`B_TRQ]                 = transmit_request[ar_addr[5:2]];
            rd_word[`B_DN]                  = dn[ar_addr[5:2]];
            rd_word[`B_MUC]                 = buffer_update_in_progress[ar_addr[5:2]];
            rd_word[`B_TYPE_HI:`B_TYPE_LO]  = btype[ar_addr[5:2]];
            rd_word[`B_ASSIGN]              = asg[ar_addr[5:2]];
        end else if (is_bdata(ar_addr)) begin
            rd_word = ram_q;
        end
    end

    // ==========================================================
    // Buffer flags, global control and transmit scheduling
    always_comb begin
        for (int i = 0; i < `NBUF; i++) begin
            elig[i] = rdy[i] && transmit_request[i] && asg[i] && btype[i] == `TYPE_TX;
            normal_set[i] = elig[i] && !(auto_block_transmission && `IDXW'(i) <= `ABT_LAST);
        end
        cand = pick(normal_set);
    end

    assign tx_stat      = tx_state != can_mb_pkg::TX_IDLE;
    assign tx_req_valid = tx_state == can_mb_pkg::TX_REQ;
    assign tx_req_index = tx_idx;
    assign tx_push      = tx_state == can_mb_pkg::TX_BUSY && tx_done;

    always_comb begin
        next_rdy      = rdy;
        next_trq      = transmit_request;
        next_dn       = dn;
        next_muc      = buffer_update_in_progress;
        next_asg      = asg;
        next_btype    = btype;
        next_abt      = auto_block_transmission;
        next_trg      = trg;
        next_buffer_access_on     = buffer_access_on;
        next_abt_ptr  = abt_ptr;
        next_tx_idx   = tx_idx;
        next_from_abt = from_abt;
        next_last_tx  = last_tx;
        next_last_rx  = last_rx;
        next_tx_state = tx_state;
        if (tx_push) begin
            next_trq[tx_idx] = 1'b0;
            next_last_tx     = tx_idx;
        end
        if (do_wr && w_strb[0] && is_bctl(aw_addr)) begin
            next_rdy[aw_addr[5:2]]   = w_data[`B_RDY];
            next_trq[aw_addr[5:2]]   = w_data[`B_TRQ];
            next_dn[aw_addr[5:2]]    = w_data[`B_DN];
            next_btype[aw_addr[5:2]] = w_data[`B_TYPE_HI:`B_TYPE_LO];
            next_asg[aw_addr[5:2]]   = w_data[`B_ASSIGN];
        end
        if (do_wr && w_strb[0] && aw_addr == `OFF_GCTRL) begin
            next_abt = w_data[`G_ABT];
            next_trg = w_data[`G_TRG];
            if (w_data[`G_TRG] && !trg) begin
                next_abt_ptr = '0;
            end
        end
        // Received data wins over a clear written in the same cycle.
        if (rx_state == can_mb_pkg::RX_WRITE) begin
            next_muc[rx_idx] = 1'b1;
        end
        if (rx_state == can_mb_pkg::RX_DONE) begin
            next_muc[rx_idx] = 1'b0;
            next_dn[rx_idx]  = 1'b1;
            next_last_rx     = rx_idx;
        end
        if (sleep_taken) begin
            next_buffer_access_on = 1'b0;
        end else if (wake_taken) begin
            next_buffer_access_on = 1'b1;
        end
        case (tx_state)
            can_mb_pkg::TX_IDLE: begin
                if (auto_block_transmission && trg && elig[abt_ptr]) begin
                    next_tx_idx   = abt_ptr;
                    next_from_abt = 1'b1;
                    next_tx_state = can_mb_pkg::TX_REQ;
                end else if (auto_block_transmission && trg) begin
                    next_abt_ptr = abt_ptr + 1'b1;
                    next_trg     = abt_ptr != `ABT_LAST;
                end else if (cand[`IDXW]) begin
                    next_tx_idx   = cand[`IDXW-1:0];
                    next_from_abt = 1'b0;
                    next_tx_state = can_mb_pkg::TX_REQ;
                end
            end
            can_mb_pkg::TX_REQ: begin
                // Until the protocol layer accepts, a cleared request withdraws the offer, and
                // the next pick may be a later, lower-priority request.
                if (!elig[tx_idx]) begin
                    next_tx_state = can_mb_pkg::TX_IDLE;
                end else if (tx_accept) begin
                    next_tx_state = can_mb_pkg::TX_BUSY;
                end
            end
            can_mb_pkg::TX_BUSY: begin
                // Once accepted the frame goes out even if its request is cleared meanwhile.
                if (tx_done) begin
                    next_tx_state = can_mb_pkg::TX_IDLE;
                    if (from_abt) begin
                        next_abt_ptr = abt_ptr + 1'b1;
                        if (abt_ptr == `ABT_LAST) begin
                            next_trg = 1'b0;
                        end
                    end
                end
            end
            default: next_tx_state = can_mb_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdy      <= '0;
            transmit_request      <= '0;
            dn       <= '0;
            buffer_update_in_progress      <= '0;
            asg      <= '0;
            btype    <= '{default: `TYPE_TX};
            auto_block_transmission      <= 1'b0;
            trg      <= 1'b0;
            buffer_access_on     <= 1'b1;
            abt_ptr  <= '0;
            tx_idx   <= '0;
            from_abt <= 1'b0;
            last_tx  <= '0;
            last_rx  <= '0;
            tx_state <= can_mb_pkg::TX_IDLE;
        end else begin
            rdy      <= next_rdy;
            transmit_request      <= next_trq;
            dn       <= next_dn;
            buffer_update_in_progress      <= next_muc;
            asg      <= next_asg;
            btype    <= next_btype;
            auto_block_transmission      <= next_abt;
            trg      <= next_trg;
            buffer_access_on     <= next_buffer_access_on;
            abt_ptr  <= next_abt_ptr;
            tx_idx   <= next_tx_idx;
            from_abt <= next_from_abt;
            last_tx  <= next_last_tx;
            last_rx  <= next_last_rx;
            tx_state <= next_tx_state;
        end
    end

    // ==========================================================
    // Receive store; a frame arriving while one is being stored is dropped.
    assign rx_push = rx_state == can_mb_pkg::RX_DONE;
    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            can_mb_pkg::RX_IDLE:  if (rx_valid) next_rx_state = can_mb_pkg::RX_WRITE;
            can_mb_pkg::RX_WRITE: next_rx_state = can_mb_pkg::RX_DONE;
            can_mb_pkg::RX_DONE:  next_rx_state = can_mb_pkg::RX_IDLE;
            default:              next_rx_state = can_mb_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state <= can_mb_pkg::RX_IDLE;
            rx_idx   <= '0;
            rx_word  <= '0;
        end else begin
            rx_state <= next_rx_state;
            if (rx_state == can_mb_pkg::RX_IDLE && rx_valid) begin
                rx_idx  <= rx_index;
                rx_word <= rx_data;
            end
        end
    end

    always_comb begin
        ram_we = '0;
        if (rx_state == can_mb_pkg::RX_WRITE) begin
            ram_we = 4'hF;
        end else if (do_wr && is_bdata(aw_addr)) begin
            ram_we = w_strb;
        end
    end

    can_mb_ram u_ram (
        .aclk  (aclk),
        .we    (ram_we),
        .waddr (rx_state == can_mb_pkg::RX_WRITE ? rx_idx : aw_addr[5:2]),
        .wdata (rx_state == can_mb_pkg::RX_WRITE ? rx_word : w_data),
        .raddr (araddr[5:2]),
        .rdata (ram_q)
    );

    can_mb_history u_tx_hist (
        .aclk (aclk), .aresetn (aresetn), .push (tx_push), .push_idx (tx_idx),
        .pop (tx_pop), .head (tx_head), .empty (tx_empty), .full (tx_full),
        .ovf_clr (do_wr && aw_addr == `OFF_GCTRL && w_strb[0] && w_data[`G_TX_HISTORY_OVERFLOW]), .ovf (tx_history_overflow)
    );

    can_mb_history u_rx_hist (
        .aclk (aclk), .aresetn (aresetn), .push (rx_push), .push_idx (rx_idx),
        .pop (rx_pop), .head (rx_head), .empty (rx_empty), .full (rx_full),
        .ovf_clr (do_wr && aw_addr == `OFF_GCTRL && w_strb[0] && w_data[`G_RX_HISTORY_OVERFLOW]), .ovf (rx_history_overflow)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_type_gates_tx: assert property (tx_req_valid |-> btype[tx_idx] == `TYPE_TX)
        else $error("offered buffer is not a transmit buffer");
    a_abt_range_only: assert property (tx_req_valid && from_abt |-> tx_idx <= `ABT_LAST)
        else $error("block transmission left buffers zero to seven");
    a_accepted_holds: assert property (tx_state == can_mb_pkg::TX_BUSY && !tx_done
        |=> tx_state == can_mb_pkg::TX_BUSY && tx_req_index == $past(tx_req_index))
        else $error("accepted frame dropped before completion");
    a_tx_in_progress_status_follows: assert property (tx_req_valid && tx_accept && elig[tx_idx]
        |=> tx_stat && !tx_req_valid)
        else $error("status flag lost after acceptance");
    a_sleep_clears_on: assert property (sleep_taken |=> !buffer_access_on)
        else $error("buffer access flag not cleared by sleep");
    a_tx_ovf_sets: assert property (tx_push && tx_full |=> tx_history_overflow)
        else $error("transmit history overflow not flagged");
    a_rx_ovf_sets: assert property (rx_push && rx_full |=> rx_history_overflow)
        else $error("receive history overflow not flagged");
    a_rx_flag_order: assert property (rx_state == can_mb_pkg::RX_WRITE
        |=> buffer_update_in_progress[rx_idx] ##1 (dn[rx_idx] && !buffer_update_in_progress[rx_idx]))
        else $error("update and new data flags out of order");

    c_block_tx_done: cover property (from_abt && tx_push && abt_ptr == `ABT_LAST);
    c_abort_offer: cover property (tx_req_valid && !elig[tx_idx]);
    c_rx_store: cover property (rx_push);
    c_overflow: cover property (tx_push && tx_full);
endmodule
`default_nettype wire

// >>> hw/can_mb_history.sv
// History list of buffer numbers with a sticky overflow flag.
`timescale 1ns/1ps
`default_nettype none
`include "can_mb_consts.svh"
module can_mb_history (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Producer
    input  wire logic              push,
    input  wire logic [`IDXW-1:0]  push_idx,
    // Consumer
    input  wire logic              pop,
    output logic      [`IDXW-1:0]  head,
    output logic                   empty,
    output logic                   full,
    // Overflow flag
    input  wire logic              ovf_clr,
    output logic                   ovf
);
    logic [`IDXW-1:0]  mem [`HDEPTH];
    logic [`HPTRW-1:0] wptr;
    logic [`HPTRW-1:0] rptr;
    logic [`HPTRW:0]   count;
    logic [`HPTRW-1:0] next_wptr;
    logic [`HPTRW-1:0] next_rptr;
    logic [`HPTRW:0]   next_count;
    logic              next_ovf;
    logic              do_push;
    logic              do_pop;

    assign empty = (count == '0);
    assign full  = (count == (`HPTRW+1)'(`HDEPTH));
    assign head  = mem[rptr];

    // An entry that finds the list full is lost, so the list no longer tells the whole story.
    always_comb begin
        do_push    = push && !full;
        do_pop     = pop && !empty;
        next_wptr  = do_push ? wptr + 1'b1 : wptr;
        next_rptr  = do_pop ? rptr + 1'b1 : rptr;
        next_count = count + {{`HPTRW{1'b0}}, do_push} - {{`HPTRW{1'b0}}, do_pop};
        next_ovf   = ovf && !ovf_clr;
        if (push && full) begin
            next_ovf = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
            ovf   <= 1'b0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
            ovf   <= next_ovf;
        end
    end

    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem[wptr] <= push_idx;
        end
    end
endmodule
`default_nettype wire

// >>> hw/can_mb_pkg.sv
// Types shared by the message-buffer handling block.
package can_mb_pkg;
    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_REQ  = 3'h2,
        TX_BUSY = 3'h4
    } tx_state_t;
    typedef enum logic [2:0] {
        RX_IDLE  = 3'h1,
        RX_WRITE = 3'h2,
        RX_DONE  = 3'h4
    } rx_state_t;
endpackage

// >>> hw/can_mb_ram.sv
// Message data store: one word per buffer, byte writes, registered read.
`timescale 1ns/1ps
`default_nettype none
`include "can_mb_consts.svh"
module can_mb_ram (
    // Clock
    input  wire logic              aclk,
    // Write port
    input  wire logic [3:0]        we,
    input  wire logic [`IDXW-1:0]  waddr,
    input  wire logic [31:0]       wdata,
    // Read port
    input  wire logic [`IDXW-1:0]  raddr,
    output logic      [31:0]       rdata
);
    logic [31:0] mem [`NBUF];

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            always_ff @(posedge aclk) begin
                if (we[b]) begin
                    mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// >>> testbench/can_proto_model.sv
// Protocol-layer stand-in: takes offered frames, completes them, injects received frames.
`timescale 1ns/1ps
`default_nettype none
module can_proto_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Transmit side
    input  wire logic        tx_req_valid,
    output logic             tx_accept,
    output logic             tx_done,
    // Receive side
    input  wire logic        rx_go,
    input  wire logic [3:0]  rx_go_idx,
    output logic             rx_valid,
    output logic [3:0]       rx_index,
    output logic [31:0]      rx_data
);
    logic [2:0] cnt;
    logic       busy;
    // ==========================================
    // Frame engine
    // Idle receive lines toggle so a stale frame never looks valid.
    always_ff @(posedge aclk) begin
        tx_accept <= 1'b0;
        tx_done   <= 1'b0;
        rx_valid  <= 1'b0;
        rx_index  <= ~rx_index;
        rx_data   <= ~rx_data;
        if (!aresetn) begin
            cnt      <= 3'h0;
            busy     <= 1'b0;
            rx_index <= 4'h0;
            rx_data  <= 32'h0;
        end else begin
            if (rx_go) begin
                rx_valid <= 1'b1;
                rx_index <= rx_go_idx;
                rx_data  <= {8{rx_go_idx}};
            end
            cnt <= cnt + 3'h1;
            if (busy && cnt == 3'h5) begin
                tx_done <= 1'b1;
                busy    <= 1'b0;
                cnt     <= 3'h0;
            end else if (!busy && !tx_req_valid) begin
                cnt <= 3'h0;
            end else if (!busy && cnt == 3'h3) begin
                tx_accept <= 1'b1;
                busy      <= 1'b1;
                cnt       <= 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_can_mb_core.sv
// Self-checking bench for the message-buffer handling block.
`timescale 1ns/1ps
`default_nettype none
module tb_can_mb_core;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, tx_req_valid, tx_accept, tx_done, rx_valid;
    logic sleep_taken = 0, wake_taken = 0, rx_go = 0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, rx_data, rd;
    logic [3:0]  wstrb = 4'hF, tx_req_index, rx_index, rx_go_idx = 4'h0;
    logic [1:0]  bresp, rresp, resp;
    int bad_count = 0, n_compared = 0, cyc = 0, i;
    always #50 aclk = ~aclk;
    can_mb_core can_mb_core_inst (.*);
    can_proto_model can_proto_model_inst (.*);
    // ==========================================
    // Bus tasks: every handshake is judged at the rising edge; the response ready stays high once raised.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
    endtask
    task automatic rdt(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
    endtask
    task automatic rx(input logic [3:0] idx);
        rx_go <= 1'b1;
        rx_go_idx <= idx;
        @(posedge aclk);
        rx_go <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test;
        end
    end
    // ==========================================
    // Test sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdt(12'h000); chk(rd, 32'h0000_0008);
        wr(12'h200, 32'h0); chk({30'h0, resp}, 32'h0000_0002);
        rdt(12'h200); chk({30'h0, resp}, 32'h0000_0002);
        wr(12'h064, 32'h0000_0081);
        wr(12'h064, 32'h0000_0083);
        rdt(12'h000); chk(rd, 32'h0000_000C);
        i = 0;
        do begin
            rdt(12'h064);
            i++;
        end while (rd[1] && i < 50);
        chk(rd, 32'h0000_0081);
        rdt(12'h004); chk(rd, 32'h0000_0009);
        rdt(12'h00C); chk(rd, 32'h0000_0009);
        wr(12'h000, 32'h0000_0001);
        wr(12'h040, 32'h0000_0081);
        wr(12'h044, 32'h0000_0081);
        wr(12'h040, 32'h0000_0083);
        wr(12'h044, 32'h0000_0083);
        rdt(12'h000); chk(rd, 32'h0000_0009);
        wr(12'h000, 32'h0000_0003);
        i = 0;
        do begin
            rdt(12'h000);
            i++;
        end while (rd[1] && i < 50);
        chk(rd, 32'h0000_0009);
        rdt(12'h00C); chk(rd, 32'h0000_0001);
        rdt(12'h004); chk(rd, 32'h0000_0000);
        wr(12'h068, 32'h0000_0081);
        wr(12'h068, 32'h0000_0083);
        wr(12'h068, 32'h0000_0081);
        rdt(12'h000); chk(rd, 32'h0000_0009);
        rdt(12'h068); chk(rd, 32'h0000_0081);
        wr(12'h068, 32'h0);
        for (i = 0; i < 8; i++) begin
            wr(12'h064, 32'h0000_0083);
            @(posedge aclk);
            chk({27'h0, tx_req_valid, tx_req_index}, 32'h0000_0019);
            repeat (12) @(posedge aclk);
        end
        rdt(12'h000); chk(rd, 32'h0000_0019);
        wr(12'h000, 32'h0000_0010);
        rx(4'h3);
        rdt(12'h04C); chk(rd, 32'h0000_0004);
        rdt(12'h08C); chk(rd, 32'h3333_3333);
        rdt(12'h008); chk(rd, 32'h0000_0003);
        for (i = 0; i < 9; i++) rx(i[3:0]);
        rdt(12'h000); chk(rd, 32'h0000_0028);
        wr(12'h000, 32'h0000_0020);
        rdt(12'h000); chk(rd, 32'h0000_0008);
        sleep_taken <= 1'b1;
        @(posedge aclk);
        sleep_taken <= 1'b0;
        rdt(12'h000); chk(rd, 32'h0000_0000);
        wake_taken <= 1'b1;
        @(posedge aclk);
        wake_taken <= 1'b0;
        rdt(12'h000); chk(rd, 32'h0000_0008);
        finish_test;
    end
endmodule
`default_nettype wire
